// File: inc/usb_ctl_pkg.sv
// Package of register map, field positions and carriers for the USB control and address block.
//
// Function
// - Bit 7 reads live J state, speed-dependent polarity.
// - Bit 6 reads live single-ended-zero line state.
// - Host role: bit 5 shows token in progress.
// - Peripheral role: bit 5 holds transmission; clear resumes.
// - SETUP token received sets the hold flag.
// - Bit 4 drives bus reset, host role only.
// - Bit 3 selects host (1) or peripheral (0).
// - Bit 2 drives resume; software times it.
// - Host role: resume clear appends low-speed EOP.
// - Writing 1 to bit 1 clears bank selects.
// - Bit 0 enables; setting resets banks, engine.
// - Host role: enable clear stops start-of-frame tokens.
// - Peripheral role: accept only tokens matching address.
// - Host role: tokens carry the address register.
// - Address clears on reset and bus reset.
// - Address bit 7 makes next token low speed.
// - Address bits 6..0 hold device address.
package usb_ctl_pkg;

	// ------------------------------------------------------------
	// Register byte addresses on the bus.
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_USB_CONTROL      = 8'h00;
	localparam logic [7:0] OFS_FUNCTION_ADDRESS = 8'h04;

	// ------------------------------------------------------------
	// Control register field positions.
	// ------------------------------------------------------------
	localparam int CTL_J_STATE  = 7;
	localparam int CTL_SE0      = 6;
	localparam int CTL_BUSY     = 5;
	localparam int CTL_BUS_RST  = 4;
	localparam int CTL_HOST     = 3;
	localparam int CTL_RESUME   = 2;
	localparam int CTL_BANK_CLR = 1;
	localparam int CTL_ENABLE   = 0;

	// ------------------------------------------------------------
	// Address register fields and reset values.
	// ------------------------------------------------------------
	localparam int ADR_SLOW = 7;
	localparam logic [7:0] CTL_RESET_VAL  = 8'h00;
	localparam logic [7:0] ADDR_RESET_VAL = 8'h00;

	// ------------------------------------------------------------
	// Bus responses.
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register write request handed from the bus port to the block.
	typedef struct packed {
		logic        en;
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} reg_wr_s;

	// Raw differential line levels from the transceiver.
	typedef struct packed {
		logic dp;
		logic dm;
	} line_s;

	// Token seen by the serial engine in peripheral role.
	typedef struct packed {
		logic       valid;
		logic       setup;
		logic [6:0] addr;
	} rx_token_s;

endpackage

// File: logic/axil_reg_port.sv
// AXI4-Lite slave port that turns bus transfers into register strobes.
`timescale 1ns/100ps
module axil_reg_port
	import usb_ctl_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output reg_wr_s          wr,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data
);

	// ------------------------------------------------------------
	// Decode and held channel state
	// ------------------------------------------------------------
	logic        aw_held_r;   // Write address captured.
	logic        w_held_r;    // Write data captured.
	logic        rd_pend_r;   // Read address captured, data next.
	logic [7:0]  awaddr_r;    // Held write address.
	logic [31:0] wdata_r;     // Held write data.
	logic [3:0]  wstrb_r;     // Held byte strobes.
	wire         wr_hit;      // Write address is mapped.
	wire         rd_hit;      // Read address is mapped.
	wire         wr_go;       // Both halves of the write are here.

	assign wr_hit = (awaddr_r == OFS_USB_CONTROL) || (awaddr_r == OFS_FUNCTION_ADDRESS);
	assign rd_hit = (rd_addr == OFS_USB_CONTROL) || (rd_addr == OFS_FUNCTION_ADDRESS);
	assign wr_go  = aw_held_r && w_held_r && !s_axi_bvalid;

	// ------------------------------------------------------------
	// Write path
	// ------------------------------------------------------------
	// Address and data are taken in either order; ready drops after each
	// take and comes back only once the response is accepted, so one write
	// at most is under way.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			awaddr_r      <= 8'h00;
			wdata_r       <= 32'h0000_0000;
			wstrb_r       <= 4'h0;
			wr            <= '0;
		end else begin
			wr.en <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r     <= 1'b1;
				awaddr_r      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r     <= 1'b1;
				wdata_r      <= s_axi_wdata;
				wstrb_r      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				// Unmapped writes change nothing and answer with an error.
				wr           <= '{en: wr_hit, addr: awaddr_r, data: wdata_r, strb: wstrb_r};
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// The data word is sampled one cycle after the address is taken.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
			rd_pend_r     <= 1'b0;
			rd_addr       <= 8'h00;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				rd_addr       <= s_axi_araddr;
				rd_pend_r     <= 1'b1;
				s_axi_arready <= 1'b0;
			end
			if (rd_pend_r) begin
				s_axi_rdata <= rd_hit ? rd_data : 32'h0000_0000;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
				s_axi_rvalid <= 1'b1;
				rd_pend_r   <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // axil_reg_port

// File: logic/usb_control_and_address.sv
// Control and address registers of the USB serial engine, with bus-side control outputs.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module usb_control_and_address
	import usb_ctl_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// AXI4-Lite register port.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Line levels and serial engine status.
	input  wire line_s       line,
	input  wire logic        token_active,
	input  wire rx_token_s   rx_token,
	input  wire logic        bus_reset_seen,
	// Controls toward the serial engine and transceiver.
	output logic             module_enable,
	output logic             host_role,
	output logic             tx_hold,
	output logic             drive_bus_reset,
	output logic             drive_resume,
	output logic             slow_eop_req,
	output logic             bank_clear,
	output logic             engine_restart,
	output logic             sof_enable,
	output logic             token_accept,
	output logic [6:0]       token_addr,
	output logic             slow_token_req
);

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	reg_wr_s     wr;          // One-cycle write strobe with payload.
	logic [7:0]  rd_addr;     // Address of the pending read.
	wire  [31:0] rd_data;     // Read word for that address.

	axil_reg_port u_port (
		.ref_clk       (ref_clk),
		.rst           (rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr            (wr),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data)
	);

	// ------------------------------------------------------------
	// Stored state
	// ------------------------------------------------------------
	logic       enable_r;        // Module enable.
	logic       host_r;          // Role select, 1 is host.
	logic       bus_rst_r;       // Bus reset request bit.
	logic       resume_r;        // Resume request bit.
	logic       hold_r;          // Peripheral transmit hold flag.
	logic [7:0] addr_r;          // Function address with speed select.
	logic       j_state_live;    // Sampled J state.
	logic       single_ended_zero_live; // Sampled single-ended zero.
	logic       dp_r;            // Sampled D+ level.
	logic       dm_r;            // Sampled D- level.

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	// Only byte lane 0 carries register bits; other lanes are dropped.
	wire        ctl_wr  = wr.en && (wr.addr == OFS_USB_CONTROL) && wr.strb[0];
	wire        adr_wr  = wr.en && (wr.addr == OFS_FUNCTION_ADDRESS) && wr.strb[0];
	wire [7:0]  wbyte   = wr.data[7:0];

	// Next values of the stored control bits.
	wire        enable_nxt = ctl_wr ? wbyte[CTL_ENABLE]  : enable_r;
	wire        host_nxt   = ctl_wr ? wbyte[CTL_HOST]    : host_r;
	wire        resume_nxt = ctl_wr ? wbyte[CTL_RESUME]  : resume_r;
	wire        bus_rst_nxt = ctl_wr ? wbyte[CTL_BUS_RST] : bus_rst_r;

	// Peripheral token decode on the incoming token.
	wire        slow_speed_select = addr_r[ADR_SLOW];
	wire [6:0]  own_addr          = addr_r[6:0];
	wire        periph_live       = enable_r && !host_r;
	wire        token_match = periph_live && rx_token.valid && (rx_token.addr == own_addr);
	wire        setup_hit   = token_match && rx_token.setup;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Bit 5 shows the engine busy flag in host role and the hold flag otherwise.
	// Busy in host role.
	wire        busy_view = host_r ? token_active : hold_r;
	wire [7:0]  ctl_view  = {j_state_live, single_ended_zero_live, busy_view,
	                         bus_rst_r, host_r, resume_r, 1'b0, enable_r};
	assign rd_data = (rd_addr == OFS_FUNCTION_ADDRESS) ? {24'h00_0000, addr_r}
	                                                   : {24'h00_0000, ctl_view};

	// ------------------------------------------------------------
	// Line sampling
	// ------------------------------------------------------------
	// The lines are sampled once so that both status bits read a
	// consistent pair; the J polarity follows the speed select because
	// a low-speed idle line pulls D- high instead of D+.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dp_r <= 1'b0;
			dm_r <= 1'b0;
		end else begin
			dp_r <= line.dp;
			dm_r <= line.dm;
		end
	end

	assign j_state_live = slow_speed_select ? (dm_r && !dp_r) : (dp_r && !dm_r);
	assign single_ended_zero_live = !dp_r && !dm_r;

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Bits 7 and 6 have no storage, so a write to them is lost by design.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			enable_r  <= CTL_RESET_VAL[CTL_ENABLE];
			host_r    <= CTL_RESET_VAL[CTL_HOST];
			resume_r  <= CTL_RESET_VAL[CTL_RESUME];
			bus_rst_r <= CTL_RESET_VAL[CTL_BUS_RST];
		end else begin
			enable_r  <= enable_nxt;
			host_r    <= host_nxt;
			resume_r  <= resume_nxt;
			bus_rst_r <= bus_rst_nxt;
		end
	end

	// ------------------------------------------------------------
	// Transmit hold flag
	// ------------------------------------------------------------
	// The engine's set wins over a software clear in the same cycle so a
	// SETUP arriving just as software resumes is never lost. Software may
	// clear the flag; setting it from software is also honoured.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hold_r <= CTL_RESET_VAL[CTL_BUSY];
		end else if (setup_hit) begin
			hold_r <= 1'b1;
		end else if (ctl_wr && !host_r) begin
			hold_r <= wbyte[CTL_BUSY];
		end
	end

	// ------------------------------------------------------------
	// Address register
	// ------------------------------------------------------------
	// A detected bus reset wins over a software write in the same cycle,
	// because the device must answer on address zero afterwards.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			addr_r <= ADDR_RESET_VAL;
		end else if (bus_reset_seen) begin
			addr_r <= ADDR_RESET_VAL;
		end else if (adr_wr) begin
			addr_r <= wbyte;
		end
	end

	// ------------------------------------------------------------
	// Bus signalling outputs
	// ------------------------------------------------------------
	// Reset signalling is meaningful only for a host; software does the
	// timing, so the output simply follows the bit while host role holds.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			drive_bus_reset <= 1'b0;
			drive_resume    <= 1'b0;
			slow_eop_req    <= 1'b0;
		end else begin
			drive_bus_reset <= bus_rst_nxt && host_nxt;
			drive_resume    <= resume_nxt;
			slow_eop_req    <= resume_r && !resume_nxt && host_r;
		end
	end

	// ------------------------------------------------------------
	// Bank clear and engine restart
	// ------------------------------------------------------------
	// Both are one-cycle pulses. Bank clear fires on a write of 1 to the
	// clear bit or on the rising edge of enable; the restart fires only on
	// the enable edge, as it disturbs the engine far more.
	wire enable_rise = enable_nxt && !enable_r;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bank_clear     <= 1'b0;
			engine_restart <= 1'b0;
		end else begin
			bank_clear     <= (ctl_wr && wbyte[CTL_BANK_CLR]) || enable_rise;
			engine_restart <= enable_rise;
		end
	end

	// ------------------------------------------------------------
	// Role, enable and frame control outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			module_enable <= 1'b0;
			host_role     <= 1'b0;
			tx_hold       <= 1'b0;
			sof_enable    <= 1'b0;
		end else begin
			module_enable <= enable_nxt;
			host_role     <= host_nxt;
			tx_hold       <= (hold_r || setup_hit) && !host_r;
			sof_enable    <= enable_nxt && host_nxt;
		end
	end

	// ------------------------------------------------------------
	// Token addressing
	// ------------------------------------------------------------
	// The host token fields go out only while enabled; a disabled module
	// presents zero so a stale address never leaks onto the wire.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			token_accept   <= 1'b0;
			token_addr     <= 7'h00;
			slow_token_req <= 1'b0;
		end else begin
			token_accept   <= token_match;
			token_addr     <= (enable_r && host_r) ? own_addr : 7'h00;
			slow_token_req <= enable_r && host_r && slow_speed_select;
		end
	end

endmodule // usb_control_and_address

// File: verification/usb_ctl_asserts.sv
// Concurrent checks on the USB control block ports.
`timescale 1ns/100ps
module usb_ctl_asserts
	import usb_ctl_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire rx_token_s   rx_token,
	input wire logic        module_enable,
	input wire logic        host_role,
	input wire logic        tx_hold,
	input wire logic        drive_bus_reset,
	input wire logic        drive_resume,
	input wire logic        slow_eop_req,
	input wire logic        bank_clear,
	input wire logic        engine_restart,
	input wire logic        sof_enable,
	input wire logic        token_accept,
	input wire logic [6:0]  token_addr,
	input wire logic        slow_token_req
);
	// --------
	// All checks run on the one clock and stop during reset.
	// --------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// A read answer waiting for the master.
	sequence s_rd_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	// A token accepted in the previous cycle.
	sequence s_acc;
		token_accept && $past(rx_token.valid) && $past(module_enable) && !$past(host_role);
	endsequence
	property p_rd_hold; s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	property p_bus_rst; drive_bus_reset |-> host_role; endproperty
	property p_sof; sof_enable == (module_enable && host_role); endproperty
	property p_restart; $rose(module_enable) |-> engine_restart && bank_clear; endproperty
	property p_bank; bank_clear |=> !bank_clear; endproperty
	property p_accept; token_accept |-> s_acc; endproperty
	property p_setup; token_accept && $past(rx_token.setup) |-> tx_hold; endproperty
	property p_eop; slow_eop_req |-> $fell(drive_resume); endproperty
	property p_tok_addr; !(module_enable && host_role) |=> token_addr == 7'h00; endproperty
	property p_slow; slow_token_req |-> $past(module_enable && host_role); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped early");
	a_bus_rst: assert property (p_bus_rst) else $error("bus reset outside host role");
	a_sof: assert property (p_sof) else $error("frame token enable wrong");
	a_restart: assert property (p_restart) else $error("enable rise without restart");
	a_bank: assert property (p_bank) else $error("bank clear not a pulse");
	a_accept: assert property (p_accept) else $error("token accepted wrongly");
	a_setup: assert property (p_setup) else $error("setup did not hold");
	a_eop: assert property (p_eop) else $error("eop without resume end");
	a_tok_addr: assert property (p_tok_addr) else $error("token address leaked");
	a_slow: assert property (p_slow) else $error("slow token outside host");
endmodule // usb_ctl_asserts

bind usb_control_and_address usb_ctl_asserts u_chk (.ref_clk(ref_clk), .rst(rst),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.rx_token(rx_token), .module_enable(module_enable), .host_role(host_role), .tx_hold(tx_hold),
	.drive_bus_reset(drive_bus_reset), .drive_resume(drive_resume), .slow_eop_req(slow_eop_req),
	.bank_clear(bank_clear), .engine_restart(engine_restart), .sof_enable(sof_enable),
	.token_accept(token_accept), .token_addr(token_addr), .slow_token_req(slow_token_req));

// File: verification/usb_bus_partner.sv
// Model of the USB bus side: line levels and engine events.
`timescale 1ns/100ps
module usb_bus_partner
	import usb_ctl_pkg::*;
(
	input  wire logic ref_clk,
	output line_s     line,
	output logic      token_active,
	output rx_token_s rx_token,
	output logic      bus_reset_seen
);
	// Idle bus rests in the full speed J state.
	initial begin
		line = '{dp: 1'b1, dm: 1'b0};
		token_active = 1'b0;
		rx_token = '0;
		bus_reset_seen = 1'b0;
	end
	// New line levels, changed just after an edge.
	task automatic set_line(input logic dp, input logic dm);
		@(posedge ref_clk);
		line <= '{dp: dp, dm: dm};
	endtask
	// Engine busy level seen in host role.
	task automatic busy(input logic v);
		@(posedge ref_clk);
		token_active <= v;
	endtask
	// One token pulse; fields are scrambled after it so stale values never match.
	task automatic token(input logic su, input logic [6:0] a);
		@(posedge ref_clk);
		rx_token <= '{valid: 1'b1, setup: su, addr: a};
		@(posedge ref_clk);
		rx_token <= '{valid: 1'b0, setup: ~su, addr: ~a};
	endtask
	// One cycle pulse for a detected bus reset.
	task automatic bus_reset();
		@(posedge ref_clk);
		bus_reset_seen <= 1'b1;
		@(posedge ref_clk);
		bus_reset_seen <= 1'b0;
	endtask
endmodule // usb_bus_partner

// File: verification/usb_control_and_address_tb.sv
// Self-checking bench for the USB control and address block.
`timescale 1ns/100ps
module usb_control_and_address_tb;
	import usb_ctl_pkg::*;
	logic ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, a;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	line_s line;
	rx_token_s rx_token;
	logic token_active, bus_reset_seen, module_enable, host_role, tx_hold, drive_bus_reset;
	logic drive_resume, sof_enable, slow_token_req;
	logic [6:0] token_addr;
	int errors = 0, n_tests = 0, cycles = 0;
	integer seed;
	logic [7:0] seq [6] = '{8'h19, 8'h0d, 8'h09, 8'h08, 8'h10, 8'h01};
	usb_control_and_address dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .line, .token_active, .rx_token, .bus_reset_seen,
		.module_enable, .host_role, .tx_hold, .drive_bus_reset, .drive_resume, .slow_eop_req(),
		.bank_clear(), .engine_restart(), .sof_enable, .token_accept(), .token_addr, .slow_token_req);
	usb_bus_partner partner (.ref_clk, .line, .token_active, .rx_token, .bus_reset_seen);
	// --------
	// Clock, timeout and verdict.
	// --------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// The tests need well under a thousand cycles, so this only trips on a hang.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// --------
	// Compares, bus cycles and expectations.
	// --------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h got %h", n, e, g);
		end
	endtask
	task automatic chk_bit(input string n, input logic e, input logic g);
		chk(n, {31'h0000_0000, e}, {31'h0000_0000, g});
	endtask
	// Write: address and data offered together, each dropped when taken.
	task automatic wr_chk(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
		@(posedge ref_clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge ref_clk); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge ref_clk); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		while (!s_axi_bvalid) @(posedge ref_clk);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0000_0000, er}, {30'h0000_0000, s_axi_bresp});
	endtask
	task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
		@(posedge ref_clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0000_0000, er}, {30'h0000_0000, s_axi_rresp});
	endtask
	// Control read back: live line bits, busy or hold bit, stored bits, bank bit reads 0.
	function automatic logic [31:0] exp_ctl(input logic [7:0] c, input logic b5, input logic slow);
		logic j;
		j = slow ? (line.dm & ~line.dp) : (line.dp & ~line.dm);
		return {24'h00_0000, j, ~line.dp & ~line.dm, b5, c[4:2], 1'b0, c[0]};
	endfunction
	// Bus side outputs: reset, resume, frame tokens, role, enable.
	function automatic logic [31:0] exp_out(input logic [7:0] c);
		return {27'h000_0000, c[4] & c[3], c[2], c[0] & c[3], c[3], c[0]};
	endfunction
	// --------
	// Main sequence.
	// --------
	initial begin
		seed = 32'h95fb;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd_chk(OFS_USB_CONTROL, exp_ctl(8'h00, 1'b0, 1'b0), RESP_OKAY); // idle J
		rd_chk(OFS_FUNCTION_ADDRESS, 32'h0000_0000, RESP_OKAY); // reset value
		wr_chk(8'h08, 32'h0000_00ff, RESP_SLVERR);
		rd_chk(8'h08, 32'h0000_0000, RESP_SLVERR);
		wr_chk(OFS_USB_CONTROL, 32'h0000_00c1, RESP_OKAY);
		rd_chk(OFS_USB_CONTROL, exp_ctl(8'h01, 1'b0, 1'b0), RESP_OKAY); // live bits kept
		$display("test reset and map done");
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 8'hff : 8'($random(seed));
			wr_chk(OFS_FUNCTION_ADDRESS, {24'h00_0000, a}, RESP_OKAY);
			partner.set_line(i[1], i[0]);
			repeat (2) @(posedge ref_clk);
			rd_chk(OFS_FUNCTION_ADDRESS, {24'h00_0000, a}, RESP_OKAY); // address held
			rd_chk(OFS_USB_CONTROL, exp_ctl(8'h01, 1'b0, a[7]), RESP_OKAY); // line status
		end
		$display("test address and line done");
		wr_chk(OFS_FUNCTION_ADDRESS, 32'h0000_002a, RESP_OKAY);
		partner.set_line(1'b1, 1'b0);
		partner.token(1'b1, 7'h2b);
		repeat (2) @(posedge ref_clk);
		chk_bit("tx_hold", 1'b0, tx_hold); // foreign address
		partner.token(1'b1, 7'h2a);
		repeat (2) @(posedge ref_clk);
		chk_bit("tx_hold", 1'b1, tx_hold); // setup holds
		rd_chk(OFS_USB_CONTROL, exp_ctl(8'h01, 1'b1, 1'b0), RESP_OKAY); // hold visible
		wr_chk(OFS_USB_CONTROL, 32'h0000_0003, RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		chk_bit("tx_hold", 1'b0, tx_hold); // clear resumes
		rd_chk(OFS_USB_CONTROL, exp_ctl(8'h01, 1'b0, 1'b0), RESP_OKAY); // bank bit reads 0
		$display("test peripheral tokens done");
		wr_chk(OFS_FUNCTION_ADDRESS, 32'h0000_00aa, RESP_OKAY);
		wr_chk(OFS_USB_CONTROL, 32'h0000_0009, RESP_OKAY);
		partner.busy(1'b1);
		repeat (2) @(posedge ref_clk);
		chk("token_addr", 32'h0000_002a, {25'h000_0000, token_addr}); // address sent
		chk_bit("slow_token_req", 1'b1, slow_token_req); // slow token
		rd_chk(OFS_USB_CONTROL, exp_ctl(8'h09, 1'b1, 1'b1), RESP_OKAY); // busy read
		partner.busy(1'b0);
		foreach (seq[k]) begin
			wr_chk(OFS_USB_CONTROL, {24'h00_0000, seq[k]}, RESP_OKAY);
			repeat (2) @(posedge ref_clk);
			chk("bus outputs", exp_out(seq[k]), {27'h000_0000, drive_bus_reset, drive_resume,
				sof_enable, host_role, module_enable}); // role and drives
			rd_chk(OFS_USB_CONTROL, exp_ctl(seq[k], 1'b0, 1'b1), RESP_OKAY); // stored bits
		end
		$display("test host controls done");
		partner.bus_reset();
		repeat (2) @(posedge ref_clk);
		rd_chk(OFS_FUNCTION_ADDRESS, 32'h0000_0000, RESP_OKAY); // bus reset clears
		$display("test bus reset done");
		print_verdict();
	end
endmodule // usb_control_and_address_tb
